// [design/serial_ctrl_mode_and_flags.sv]
/*
   Mode select and interrupt-flag front end shared by the two serial
   controllers: mode registers, pending flags, enables, trigger selects,
   one interrupt line, the registers reached over a classic Wishbone slave.
   Assumes event sources arrive from the link side, outside the clk
   domain: pulse events as toggles, condition sources as levels that
   change on the sampled link clock's rising edge.
*/
`include "serial_ctrl_defines.svh"
`default_nettype none

module serial_ctrl_mode_and_flags (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`SC_ADR_W-1:0] wb_adr_i,
   input wire logic [`SC_SEL_W-1:0] wb_sel_i,
   input wire logic [`SC_DAT_W-1:0] wb_dat_i,
   output logic [`SC_DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic linkClk,
   input wire logic [`SC_TOG_W-1:0] unitOneEvtToggle,
   input wire logic [`SC_TRIG_W-1:0] unitOneCond,
   input wire logic [`SC_TOG_W-3:0] unitTwoEvtToggle,
   input wire logic [`SC_TRIG_W-1:0] unitTwoCond,
   output logic [`SERIAL_OPERATING_SELECT_W-1:0] unitOneSelect,
   output logic [`SERIAL_OPERATING_SELECT_W-1:0] unitTwoSelect,
   output logic unitOneFifoDmaEn,
   output logic unitTwoFifoDmaEn,
   output logic unitOneTwiMasterEn,
   output logic unitTwoTwiMasterEn,
   output logic unitOneSpiEn,
   output logic unitTwoSpiEn,
   output logic unitOneUartEn,
   output logic irq
);
   localparam int SYNC_W = 1 + `SC_UNITS * (`SC_TOG_W + `SC_TRIG_W);

   // synchronised link-side inputs
   logic [SYNC_W-1:0] syncIn, syncLevel, syncChange, syncRise;
   logic linkRise;
   logic [`SC_TOG_W-1:0] evtToggle [`SC_UNITS];
   logic [`SC_TOG_W-1:0] evtChange [`SC_UNITS];
   logic [`SC_TRIG_W-1:0] condLevel [`SC_UNITS];

   // register state, one slot per unit
   serial_ctrl_pkg::serial_operating_select_type modeReg [`SC_UNITS];
   serial_ctrl_pkg::serial_operating_select_type modeNext [`SC_UNITS];
   logic [`SC_PEND_W-1:0] pendReg [`SC_UNITS];
   logic [`SC_PEND_W-1:0] pendNext [`SC_UNITS];
   logic [`SC_PEND_W-1:0] enReg [`SC_UNITS];
   logic [`SC_PEND_W-1:0] enNext [`SC_UNITS];
   logic [`SC_TRIG_W-1:0] trigReg [`SC_UNITS];
   logic [`SC_TRIG_W-1:0] trigNext [`SC_UNITS];
   logic [`SC_TRIG_W-1:0] condHeldReg [`SC_UNITS];
   logic [`SC_TRIG_W-1:0] condHeldNext [`SC_UNITS];
   logic [`SC_TRIG_W-1:0] condPrevReg [`SC_UNITS];
   logic [`SC_TRIG_W-1:0] condPrevNext [`SC_UNITS];
   logic [`SC_PEND_W-1:0] setVec [`SC_UNITS];
   logic [`SC_PEND_W-1:0] allowVec [`SC_UNITS];
   logic [`SC_UNITS-1:0] unitIrq;

   // bus slave state
   logic ackReg, ackNext;
   logic [`SC_DAT_W-1:0] datReg, datNext;
   logic busReq, readTake, writeTake;
   logic [`SC_PEND_W-1:0] wrMask15;
   logic [`SC_DAT_W-1:0] readData;

   // address hits per unit
   logic [`SC_UNITS-1:0] hitMode, hitPend, hitEn, hitTrig;

   // one synchroniser for the link clock and every event line
   assign syncIn = {unitTwoCond, 2'h0, unitTwoEvtToggle, unitOneCond, unitOneEvtToggle, linkClk};

   serial_sync3 #(
      .WIDTH(SYNC_W)
   ) inputSync (
      .clk(clk),
      .rst_n(rst_n),
      .asyncIn(syncIn),
      .levelOut(syncLevel),
      .changeOut(syncChange),
      .riseOut(syncRise)
   );

   assign linkRise = syncRise[0];

   // address decode
   always_comb begin
      hitMode[0] = (wb_adr_i == `SERIAL_OPERATING_SELECT_ONE_ADR);
      hitMode[1] = (wb_adr_i == `SERIAL_OPERATING_SELECT_TWO_ADR);
      hitPend[0] = (wb_adr_i == `SC_PEND_ONE_ADR);
      hitPend[1] = (wb_adr_i == `SC_PEND_TWO_ADR);
      hitEn[0] = (wb_adr_i == `SC_EN_ONE_ADR);
      hitEn[1] = (wb_adr_i == `SC_EN_TWO_ADR);
      hitTrig[0] = (wb_adr_i == `SC_TRIG_ONE_ADR);
      hitTrig[1] = (wb_adr_i == `SC_TRIG_TWO_ADR);
   end

   // reads are sampled on the first cycle, writes land on the ack edge
   always_comb begin
      busReq = wb_cyc_i && wb_stb_i;
      readTake = busReq && !ackReg && !wb_we_i;
      writeTake = busReq && ackReg && wb_we_i;
      wrMask15 = {{7{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   end

   // read mux; upper bits of every register read as zero
   always_comb begin
      readData = `SC_UNMAPPED_DATA;
      for (int u = 0; u < `SC_UNITS; u++) begin
         if (hitMode[u]) begin
            readData = {{(`SC_DAT_W-`SERIAL_OPERATING_SELECT_W){1'b0}}, modeReg[u]};
         end
         if (hitPend[u]) begin
            readData = {{(`SC_DAT_W-`SC_PEND_W){1'b0}}, pendReg[u]};
         end
         if (hitEn[u]) begin
            readData = {{(`SC_DAT_W-`SC_PEND_W){1'b0}}, enReg[u]};
         end
         if (hitTrig[u]) begin
            readData = {{(`SC_DAT_W-`SC_TRIG_W){1'b0}}, trigReg[u]};
         end
      end
   end

   // one wait state: ack follows the request by one edge, then drops
   always_comb begin
      ackNext = busReq && !ackReg;
      datNext = datReg;
      if (readTake) begin
         datNext = readData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ackReg <= 1'b0;
         datReg <= `SC_UNMAPPED_DATA;
      end else begin
         ackReg <= ackNext;
         datReg <= datNext;
      end
   end

   assign wb_ack_o = ackReg;
   assign wb_dat_o = datReg;

   // split the synchronised bus back into per-unit groups
   always_comb begin
      evtToggle[0] = syncLevel[`SC_TOG_W:1];
      evtChange[0] = syncChange[`SC_TOG_W:1];
      condLevel[0] = syncLevel[`SC_TOG_W+`SC_TRIG_W:`SC_TOG_W+1];
      evtToggle[1] = syncLevel[2*`SC_TOG_W+`SC_TRIG_W:`SC_TOG_W+`SC_TRIG_W+1];
      evtChange[1] = syncChange[2*`SC_TOG_W+`SC_TRIG_W:`SC_TOG_W+`SC_TRIG_W+1];
      condLevel[1] = syncLevel[SYNC_W-1:2*`SC_TOG_W+`SC_TRIG_W+1];
   end

   genvar g;
   generate
      for (g = 0; g < `SC_UNITS; g++) begin : unitGen
         logic [`SC_TRIG_W-1:0] condEdge;
         logic isUart, isSpi, isTwi, hasBuffers, isOn;
         logic [`SC_PEND_W-1:0] clearVec;

         // mode decode; twi here is always the master role
         always_comb begin
            isUart = (modeReg[g] == serial_ctrl_pkg::SEL_UART);
            isSpi = (modeReg[g] == serial_ctrl_pkg::SEL_SPI);
            isTwi = (modeReg[g] == serial_ctrl_pkg::SEL_TWI);
            hasBuffers = isSpi || isUart;
            isOn = (modeReg[g] != serial_ctrl_pkg::SEL_OFF);
         end

         // which sources may raise a flag in the present mode
         always_comb begin
            allowVec[g] = '0;
            allowVec[g][`SC_BIT_PARITY] = isUart;
            allowVec[g][`SC_BIT_FRAMING] = isUart;
            allowVec[g][`SC_BIT_TXDMA_B:`SC_BIT_RXDMA_A] = {4{hasBuffers}};
            allowVec[g][`SC_BIT_NACK] = isTwi;
            allowVec[g][`SC_BIT_CMD] = isTwi;
            allowVec[g][`SC_BIT_TXDONE:`SC_BIT_RXDONE] = {2{isTwi}};
            allowVec[g][`SC_BIT_UNDERRUN:`SC_BIT_OVERRUN] = {2{hasBuffers}};
            allowVec[g][`SC_BIT_TXIDLE:`SC_BIT_RXDATA] = {3{isOn}};
         end

         // condition levels held between link edges so a half-moved level is never seen
         always_comb begin
            condHeldNext[g] = condHeldReg[g];
            if (linkRise) begin
               condHeldNext[g] = condLevel[g];
            end
            condPrevNext[g] = condHeldReg[g];
            condEdge = condHeldReg[g] & ~condPrevReg[g];
         end

         // toggles give pulse events; conditions are edge or level per select
         always_comb begin
            setVec[g] = '0;
            setVec[g][`SC_PEND_W-1:`SC_TOG_LO] = evtChange[g];
            for (int b = 0; b < `SC_TRIG_W; b++) begin
               setVec[g][b] = trigReg[g][b] ? condHeldReg[g][b] : condEdge[b];
            end
            setVec[g] = setVec[g] & allowVec[g];
         end

         // clear by read, or by writing ones; a simultaneous set wins
         always_comb begin
            clearVec = '0;
            if (readTake && hitPend[g]) begin
               clearVec = '1;
            end
            if (writeTake && hitPend[g]) begin
               clearVec = wb_dat_i[`SC_PEND_W-1:0] & wrMask15;
            end
            pendNext[g] = (pendReg[g] & ~clearVec) | setVec[g];
         end

         // configuration writes; uart on unit two is refused and the old mode kept
         always_comb begin
            modeNext[g] = modeReg[g];
            enNext[g] = enReg[g];
            trigNext[g] = trigReg[g];
            if (writeTake && hitMode[g] && wb_sel_i[0]) begin
               if (!(g != 0 && wb_dat_i[`SERIAL_OPERATING_SELECT_W-1:0] == `SERIAL_OPERATING_SELECT_W'(serial_ctrl_pkg::SEL_UART))) begin
                  modeNext[g] = serial_ctrl_pkg::serial_operating_select_type'(wb_dat_i[`SERIAL_OPERATING_SELECT_W-1:0]);
               end
            end
            if (writeTake && hitEn[g]) begin
               enNext[g] = (enReg[g] & ~wrMask15) | (wb_dat_i[`SC_PEND_W-1:0] & wrMask15);
            end
            if (writeTake && hitTrig[g] && wb_sel_i[0]) begin
               trigNext[g] = wb_dat_i[`SC_TRIG_W-1:0];
            end
         end

         always_ff @(posedge clk) begin
            if (!rst_n) begin
               modeReg[g] <= serial_ctrl_pkg::SEL_OFF;
               pendReg[g] <= `SC_PEND_RST;
               enReg[g] <= `SC_EN_RST;
               trigReg[g] <= `SC_TRIG_RST;
               condHeldReg[g] <= `SC_COND_RST;
               condPrevReg[g] <= `SC_COND_RST;
            end else begin
               modeReg[g] <= modeNext[g];
               pendReg[g] <= pendNext[g];
               enReg[g] <= enNext[g];
               trigReg[g] <= trigNext[g];
               condHeldReg[g] <= condHeldNext[g];
               condPrevReg[g] <= condPrevNext[g];
            end
         end

         // pending flags gated by their enables
         assign unitIrq[g] = |(pendReg[g] & enReg[g]);
      end
   endgenerate

   // unit-two toggle slots of the uart pair are tied to zero; their change is dropped by allowVec
   assign irq = |unitIrq;

   // decoded mode outputs for the shift engines
   assign unitOneSelect = modeReg[0];
   assign unitTwoSelect = modeReg[1];
   assign unitOneFifoDmaEn = (modeReg[0] == serial_ctrl_pkg::SEL_SPI) || (modeReg[0] == serial_ctrl_pkg::SEL_UART);
   assign unitTwoFifoDmaEn = (modeReg[1] == serial_ctrl_pkg::SEL_SPI);
   assign unitOneTwiMasterEn = (modeReg[0] == serial_ctrl_pkg::SEL_TWI);
   assign unitTwoTwiMasterEn = (modeReg[1] == serial_ctrl_pkg::SEL_TWI);
   assign unitOneSpiEn = (modeReg[0] == serial_ctrl_pkg::SEL_SPI);
   assign unitTwoSpiEn = (modeReg[1] == serial_ctrl_pkg::SEL_SPI);
   assign unitOneUartEn = (modeReg[0] == serial_ctrl_pkg::SEL_UART);
endmodule

`default_nettype wire

// [design/serial_ctrl_defines.svh]
/*
   Address map, field positions, reset values and widths of the serial
   controller mode and interrupt-flag front end.
   Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
`ifndef SERIAL_CTRL_DEFINES_SVH
`define SERIAL_CTRL_DEFINES_SVH

// bus widths
`define SC_ADR_W 32
`define SC_DAT_W 32
`define SC_SEL_W 4

// register byte addresses
`define SERIAL_OPERATING_SELECT_ONE_ADR 32'h4000_c854
`define SERIAL_OPERATING_SELECT_TWO_ADR 32'h4000_c054
`define SC_PEND_ONE_ADR 32'h4000_a840
`define SC_PEND_TWO_ADR 32'h4000_a844
`define SC_EN_ONE_ADR 32'h4000_a848
`define SC_EN_TWO_ADR 32'h4000_a84c
`define SC_TRIG_ONE_ADR 32'h4000_a854
`define SC_TRIG_TWO_ADR 32'h4000_a858
`define SC_UNMAPPED_DATA 32'h0000_0000

// field widths
`define SERIAL_OPERATING_SELECT_W 2
`define SC_PEND_W 15
`define SC_TRIG_W 3
`define SC_TOG_W 12
`define SC_UNITS 2

// pending / enable bit positions
`define SC_BIT_PARITY 14
`define SC_BIT_FRAMING 13
`define SC_BIT_TXDMA_B 12
`define SC_BIT_TXDMA_A 11
`define SC_BIT_RXDMA_B 10
`define SC_BIT_RXDMA_A 9
`define SC_BIT_NACK 8
`define SC_BIT_CMD 7
`define SC_BIT_TXDONE 6
`define SC_BIT_RXDONE 5
`define SC_BIT_UNDERRUN 4
`define SC_BIT_OVERRUN 3
`define SC_BIT_TXIDLE 2
`define SC_BIT_TXSPACE 1
`define SC_BIT_RXDATA 0
`define SC_TOG_LO 3

// reset values
`define SERIAL_OPERATING_SELECT_RST 2'h0
`define SC_PEND_RST 15'h0000
`define SC_EN_RST 15'h0000
`define SC_TRIG_RST 3'h0
`define SC_COND_RST 3'h0

`endif

// [design/serial_ctrl_pkg.sv]
/*
   Types shared by the serial controller front end.
   Assumes serial_ctrl_defines.svh supplies all numeric constants.
*/
`default_nettype none

package serial_ctrl_pkg;
   // operating select codes in order: 0 off, 1 uart, 2 spi, 3 twi
   typedef enum logic [1:0] {
      SEL_OFF,
      SEL_UART,
      SEL_SPI,
      SEL_TWI
   } serial_operating_select_type;
endpackage

`default_nettype wire

// [design/serial_sync3.sv]
/*
   Three-stage synchroniser with agreement filter for a bus of
   independent single-bit inputs from outside the clk domain.
   Assumes each bit is a level that stays put for a few clk periods.
*/
`include "serial_ctrl_defines.svh"
`default_nettype none

module serial_sync3 #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] levelOut,
   output logic [WIDTH-1:0] changeOut,
   output logic [WIDTH-1:0] riseOut
);
   logic [WIDTH-1:0] stage1Reg, stage2Reg, stage3Reg, stableReg;
   logic [WIDTH-1:0] stableNext, agree;

   // a change counts only once stages two and three agree
   always_comb begin
      agree = ~(stage2Reg ^ stage3Reg);
      stableNext = (stableReg & ~agree) | (stage3Reg & agree);
      changeOut = stableNext ^ stableReg;
      riseOut = stableNext & ~stableReg;
   end

   // stage one feeds stage two only, to keep metastability contained
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stage1Reg <= '0;
         stage2Reg <= '0;
         stage3Reg <= '0;
         stableReg <= '0;
      end else begin
         stage1Reg <= asyncIn;
         stage2Reg <= stage1Reg;
         stage3Reg <= stage2Reg;
         stableReg <= stableNext;
      end
   end

   assign levelOut = stableReg;
endmodule

`default_nettype wire

// [dv/serial_ctrl_mode_and_flags_properties.sv]
/* port checker of the mode and flag front end.
   assumes it is bound onto the design from the bench top. */
`include "serial_ctrl_defines.svh"
`default_nettype none
module serial_ctrl_mode_and_flags_properties (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`SC_ADR_W-1:0] wb_adr_i,
   input wire logic [`SC_SEL_W-1:0] wb_sel_i,
   input wire logic [`SC_DAT_W-1:0] wb_dat_i,
   input wire logic [`SC_DAT_W-1:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic linkClk,
   input wire logic [`SC_TOG_W-1:0] unitOneEvtToggle,
   input wire logic [`SC_TRIG_W-1:0] unitOneCond,
   input wire logic [`SC_TOG_W-3:0] unitTwoEvtToggle,
   input wire logic [`SC_TRIG_W-1:0] unitTwoCond,
   input wire logic [`SERIAL_OPERATING_SELECT_W-1:0] unitOneSelect,
   input wire logic [`SERIAL_OPERATING_SELECT_W-1:0] unitTwoSelect,
   input wire logic unitOneFifoDmaEn,
   input wire logic unitTwoFifoDmaEn,
   input wire logic unitOneTwiMasterEn,
   input wire logic unitTwoTwiMasterEn,
   input wire logic unitOneSpiEn,
   input wire logic unitTwoSpiEn,
   input wire logic unitOneUartEn,
   input wire logic irq
);
   logic modeOneWr;
   logic rdFree;
   logic [1:0] wrMode;
   // mode one write at its ack edge; only lane 0 holds the field
   assign modeOneWr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `SERIAL_OPERATING_SELECT_ONE_ADR;
   assign wrMode = wb_dat_i[1:0];
   assign rdFree = !wb_we_i && !(wb_adr_i inside {`SERIAL_OPERATING_SELECT_ONE_ADR, `SERIAL_OPERATING_SELECT_TWO_ADR, `SC_PEND_ONE_ADR,
      `SC_PEND_TWO_ADR, `SC_EN_ONE_ADR, `SC_EN_TWO_ADR, `SC_TRIG_ONE_ADR, `SC_TRIG_TWO_ADR});
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // request seen by the slave, then its answer
   sequence sTake;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence sFreeRead;
      sTake ##0 rdFree;
   endsequence
   a_ack_one_wait: assert property (sTake |=> wb_ack_o) else $error("ack late");
   a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
   a_free_read_zero: assert property (sFreeRead |=> wb_dat_o == 32'h0000_0000) else $error("free read");
   a_upper_read_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:15] == 17'h0_0000)
      else $error("upper bits set");
   a_mode_one_write: assert property (modeOneWr |=> unitOneSelect == $past(wrMode)) else $error("mode lost");
   a_mode_one_hold: assert property ($changed(unitOneSelect) |-> $past(modeOneWr)) else $error("mode moved");
   a_two_no_uart: assert property (unitTwoSelect != 2'h1) else $error("uart on two");
   a_one_decode: assert property (unitOneFifoDmaEn == (unitOneSelect inside {2'h1, 2'h2}) && unitOneUartEn ==
      (unitOneSelect == 2'h1) && unitOneSpiEn == (unitOneSelect == 2'h2) && unitOneTwiMasterEn ==
      (unitOneSelect == 2'h3)) else $error("decode one");
   a_two_decode: assert property (unitTwoFifoDmaEn == (unitTwoSelect == 2'h2) && unitTwoSpiEn ==
      (unitTwoSelect == 2'h2) && unitTwoTwiMasterEn == (unitTwoSelect == 2'h3)) else $error("decode two");
endmodule
`default_nettype wire

// [dv/serial_link_source_model.sv]
/* far side model: free link clock and event sources of both units.
   assumes the bench calls its tasks right after a clk edge. */
`include "serial_ctrl_defines.svh"
`default_nettype none
module serial_link_source_model (
   input wire logic clk,
   output logic linkClk,
   output logic [`SC_TOG_W-1:0] unitOneEvtToggle,
   output logic [`SC_TRIG_W-1:0] unitOneCond,
   output logic [`SC_TOG_W-3:0] unitTwoEvtToggle,
   output logic [`SC_TRIG_W-1:0] unitTwoCond
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [`SC_TRIG_W-1:0] oneNext;
   logic [`SC_TRIG_W-1:0] twoNext;
   // odd start offset keeps the link clock apart from clk
   initial begin
      linkClk = 1'b0;
      unitOneEvtToggle = 12'h000;
      unitTwoEvtToggle = 10'h000;
      unitOneCond = 3'h0;
      unitTwoCond = 3'h0;
      oneNext = 3'h0;
      twoNext = 3'h0;
      #7;
      forever #80 linkClk = ~linkClk;
   end
   // conditions only move with the link clock, as real engines do
   always @(posedge linkClk) begin
      unitOneCond <= oneNext;
      unitTwoCond <= twoNext;
   end
   // one event per flipped bit
   task automatic fire(input logic [11:0] one, input logic [9:0] two);
      @(posedge clk);
      unitOneEvtToggle <= unitOneEvtToggle ^ one;
      unitTwoEvtToggle <= unitTwoEvtToggle ^ two;
   endtask
   task automatic setCond(input logic [2:0] one, input logic [2:0] two);
      oneNext = one;
      twoNext = two;
   endtask
endmodule
`default_nettype wire

// [dv/serial_ctrl_mode_and_flags_tb.sv]
/* self-checking bench of the mode and flag front end.
   assumes the checker and link model files are compiled first. */
`include "serial_ctrl_defines.svh"
`default_nettype none
module serial_ctrl_mode_and_flags_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, linkClk, irq, unitOneUartEn;
   logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
   logic [3:0] wb_sel_i;
   logic [11:0] unitOneEvtToggle;
   logic [9:0] unitTwoEvtToggle;
   logic [2:0] unitOneCond, unitTwoCond;
   logic [1:0] unitOneSelect, unitTwoSelect;
   logic unitOneFifoDmaEn, unitTwoFifoDmaEn, unitOneTwiMasterEn, unitTwoTwiMasterEn, unitOneSpiEn, unitTwoSpiEn;
   logic [31:0] expQ[$];
   int failures = 0;
   int n_compared = 0;
   int seed = 72;
   // mode, pending, enable, trigger per unit, then a free place
   localparam logic [31:0] ADRS [9] = '{`SERIAL_OPERATING_SELECT_ONE_ADR, `SERIAL_OPERATING_SELECT_TWO_ADR, `SC_PEND_ONE_ADR, `SC_PEND_TWO_ADR,
      `SC_EN_ONE_ADR, `SC_EN_TWO_ADR, `SC_TRIG_ONE_ADR, `SC_TRIG_TWO_ADR, 32'h4000_a850};
   serial_ctrl_mode_and_flags i_serial_ctrl_mode_and_flags (.*);
   serial_link_source_model i_serial_link_source_model (.*);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // one classic cycle; waits for ack, then one idle edge
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      @(posedge clk);
      while (wb_ack_o !== 1'b1) @(posedge clk);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      expQ.push_back(e);
      bus(1'b0, a, 32'h0000_0000, 4'hf);
   endtask
   function automatic logic [14:0] allow(input int u, input int m);
      case (m)
         1: return (u == 1) ? 15'h7e18 : 15'h0000;
         2: return 15'h1e18;
         3: return 15'h01e0;
         default: return 15'h0000;
      endcase
   endfunction
   // read data is judged against the oldest note
   always @(posedge clk) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) check("read data", wb_dat_o, expQ.pop_front());
   end
   initial begin
      #200_000;
      failures++;
      complete_run();
   end
   initial begin
      logic [31:0] r, e;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 32'h0000_0000;
      wb_dat_i = 32'h0000_0000;
      wb_sel_i = 4'h0;
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      foreach (ADRS[i]) rd(ADRS[i], 32'h0000_0000);
      // every mode code on both units, with the events each allows
      for (int u = 1; u <= 2; u++) begin
         for (int m = 0; m < 4; m++) begin
            r = $random(seed);
            bus(1'b1, ADRS[u-1], {r[31:2], m[1:0]}, 4'hf);
            rd(ADRS[u-1], (u == 2 && m == 1) ? 32'h0 : m);
            i_serial_link_source_model.fire(u == 1 ? 12'hfff : 12'h000, u == 2 ? 10'h3ff : 10'h000);
            repeat (10) @(posedge clk);
            e = $random(seed);
            bus(1'b1, ADRS[u+3], e, 4'hf);
            check("irq", irq, |(allow(u, m) & e[14:0]));
            r = $random(seed);
            bus(1'b1, ADRS[u+1], r, 4'h3);
            rd(ADRS[u+1], {17'h0_0000, allow(u, m) & ~r[14:0]});
            rd(ADRS[u+1], 32'h0000_0000);
            rd(ADRS[u+3], {17'h0_0000, e[14:0]});
            check("irq", irq, 1'b0);
         end
      end
      // trigger select, enables, and the mode written last
      bus(1'b1, ADRS[6], 32'h0000_0000, 4'hf);
      bus(1'b1, ADRS[4], 32'h0000_0007, 4'hf);
      bus(1'b1, ADRS[0], 32'h0000_0002, 4'hf);
      i_serial_link_source_model.setCond(3'h7, 3'h0);
      repeat (30) @(posedge clk);
      check("irq", irq, 1'b1);
      rd(ADRS[2], 32'h0000_0007);
      rd(ADRS[2], 32'h0000_0000);
      bus(1'b1, ADRS[6], 32'h0000_0007, 4'hf);
      rd(ADRS[6], 32'h0000_0007);
      rd(ADRS[2], 32'h0000_0007);
      rd(ADRS[2], 32'h0000_0007);
      i_serial_link_source_model.setCond(3'h0, 3'h0);
      repeat (30) @(posedge clk);
      rd(ADRS[2], 32'h0000_0007);
      rd(ADRS[2], 32'h0000_0000);
      check("irq", irq, 1'b0);
      complete_run();
   end
endmodule
bind serial_ctrl_mode_and_flags serial_ctrl_mode_and_flags_properties i_props (.*);
`default_nettype wire
